// ---- asfb_top.sv ----
// Two-channel async serial unit: frame format, bit-rate generation, transmitter.
// Assumes an I/O-mapped CPU port on clk_i; CTS and data clock pins are asynchronous.
// Function
// - Normal frame is start, 7 or 8 data, optional parity, 1 or 2 stops.
// - Multiprocessor frame is start, data, address-wake bit, stops, never parity.
// - With multiprocessor off, frame comes from width, parity-enable and stop fields.
// - Address-wake bit sent equals the address-bit-to-send control bit.
// - Address-bit-to-send has no reset value.
// - Reading the CTS/prescale bit returns the live CTS pin level.
// - CTS pin high forces the transmit-buffer-empty flag to 0.
// - Channel 1 CTS shares the clocked-serial receive pin, valid when selected.
// - Reset does not change the CTS/prescale read value.
// - Written CTS/prescale bit selects prescale 30 or 10; reset gives 10.
// - Odd-parity select gives even at 0, odd at 1; reset clears it.
// - Odd-parity select sets sense only; parity-enable decides presence.
// - Divide select gives 16 at 0 or 64 at 1; reset clears it.
// - Clock-source field picks internal or external clock; reset sets all ones.
// - External data clock pins are shared with DMA request and end lines.
// - Clock-source codes 0..6 divide by 1..64; code 7 uses external pin.
// - After reset pins are clock inputs; DMA memory-I/O mode reclaims pin 0.
`timescale 1ns/10ps
`default_nettype none
module asfb_top (
    input  wire logic       clk_i,              // 25 MHz system clock
    input  wire logic       reset_n_i,          // Synchronous reset, low active
    input  wire logic [7:0] io_addr_i,          // I/O address
    input  wire logic       io_wr_i,            // Write strobe, one cycle
    input  wire logic       io_rd_i,            // Read strobe, one cycle
    input  wire logic [7:0] io_wdata_i,         // Write data
    output logic      [7:0] io_rdata_o,         // Read data, valid cycle after strobe
    input  wire logic [1:0] cts_pin_i,          // Clear-to-send pins, high inhibits
    input  wire logic       ch1_cts_pin_select_i,// Channel 1 pin acts as CTS
    input  wire logic [1:0] ext_clk_pin_i,      // External data clock pins
    input  wire logic       dma0_io_mode_i,     // DMA channel 0 in memory-I/O mode
    output logic      [1:0] txd_o,              // Serial data out, idle high
    output logic      [1:0] tx_buffer_empty_flag_o, // Buffer has room and CTS allows
    output logic            ck0_is_dma_o,       // Pin 0 serves as DMA request
    output logic            ck1_is_dma_o        // Pin 1 serves as DMA end
);
    localparam int FW = asfb_pkg::FRAME_W;

    function automatic asfb_pkg::asfb_frame_s build_frame(input asfb_pkg::asfb_fmt_s f,
                                                          input logic [7:0] d);
        asfb_pkg::asfb_frame_s r;
        logic [7:0] dm;
        logic [3:0] pos;
        logic       extra;
        r.bits = '1;
        r.bits[0] = 1'b0;
        dm  = f.w8 ? d : {1'b0, d[6:0]};
        pos = f.w8 ? 4'h9 : 4'h8;
        for (int i = 0; i < 8; i++) begin
            if (i < 7 || f.w8) begin
                r.bits[1+i] = dm[i];
            end
        end
        extra = f.mp ? f.abts : (^dm ^ f.odd);
        if (f.mp || f.par_en) begin
            r.bits[pos] = extra;
            pos = 4'(pos + 4'h1);
        end
        r.len = 4'(pos + (f.stop2 ? 4'h2 : 4'h1));
        return r;
    endfunction

    // Pin synchronisers; stage one is read only by stage two
    logic [1:0] cts_m_q, cts_s_q, ck_m_q, ck_s_q, ck_p_q;
    always_ff @(posedge clk_i) begin
        cts_m_q <= cts_pin_i;
        cts_s_q <= cts_m_q;
        ck_m_q  <= ext_clk_pin_i;
        ck_s_q  <= ck_m_q;
        ck_p_q  <= ck_s_q;
    end
    wire [1:0] ck_rise = ck_s_q & ~ck_p_q;

    // Channel 1 pin only carries CTS when selected
    wire [1:0] cts_eff = {cts_s_q[1] & ch1_cts_pin_select_i, cts_s_q[0]};

    logic [2:0] mod_q [2];
    logic       ckdis_q [2];
    logic       mp_q [2];
    logic       ps_q [2];
    logic       odd_q [2];
    logic       dr_q [2];
    logic [2:0] ss_q [2];
    logic       abts_q [2];

    logic [4:0] pre_cnt_q [2];
    logic [5:0] ss_cnt_q [2];
    logic [5:0] bit_cnt_q [2];
    logic [1:0] pre_tick, samp_tick, bit_tick;

    asfb_pkg::asfb_tx_state_e st_q [2];
    logic [FW-1:0] sh_q [2];
    logic [3:0]    left_q [2];
    logic [1:0]    txd_q, tx_buffer_empty_flag_q;
    logic [1:0]    buf_rdy, buf_vld, take;
    logic [7:0]    buf_dat [2];
    asfb_pkg::asfb_frame_s frm [2];
    logic [1:0]    wr_a, wr_b, wr_t;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign wr_a[c] = io_wr_i && (io_addr_i == 8'(asfb_pkg::ADDR_CTRL_A0 + c));
        assign wr_b[c] = io_wr_i && (io_addr_i == 8'(asfb_pkg::ADDR_CTRL_B0 + c));
        assign wr_t[c] = io_wr_i && (io_addr_i == 8'(asfb_pkg::ADDR_TXD0 + c));

        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                mod_q[c]   <= asfb_pkg::MOD_RESET;
                ckdis_q[c] <= 1'b0;
                mp_q[c]    <= 1'b0;
                ps_q[c]    <= 1'b0;
                odd_q[c]   <= 1'b0;
                dr_q[c]    <= 1'b0;
                ss_q[c]    <= asfb_pkg::SS_RESET;
            end else begin
                if (wr_a[c]) begin
                    mod_q[c]   <= io_wdata_i[asfb_pkg::A_WIDTH:asfb_pkg::A_STOP];
                    ckdis_q[c] <= io_wdata_i[asfb_pkg::A_CKDIS];
                end
                if (wr_b[c]) begin
                    mp_q[c]  <= io_wdata_i[asfb_pkg::B_MP];
                    ps_q[c]  <= io_wdata_i[asfb_pkg::B_CTSPS];
                    odd_q[c] <= io_wdata_i[asfb_pkg::B_ODD];
                    dr_q[c]  <= io_wdata_i[asfb_pkg::B_DR];
                    ss_q[c]  <= io_wdata_i[asfb_pkg::B_SS_HI:0];
                end
            end
        end

        // Deliberately outside reset: software must load it before use
        always_ff @(posedge clk_i) begin
            if (wr_b[c]) begin
                abts_q[c] <= io_wdata_i[asfb_pkg::B_ABTS];
            end
        end

        // Prescaler, source ratio and 16/64 divider in series
        wire [4:0] pre_m1 = ps_q[c] ? asfb_pkg::PRESCALE_HI_M1 : asfb_pkg::PRESCALE_LO_M1;
        wire [5:0] ss_m1  = 6'((7'h01 << ss_q[c]) - 7'h01);
        wire [5:0] div_m1 = dr_q[c] ? asfb_pkg::DIV_HI_M1 : asfb_pkg::DIV_LO_M1;
        wire       ext    = (ss_q[c] == asfb_pkg::SS_EXT);
        assign pre_tick[c]  = (pre_cnt_q[c] == pre_m1);
        assign samp_tick[c] = ext ? ck_rise[c] : (pre_tick[c] && ss_cnt_q[c] == ss_m1);
        assign bit_tick[c]  = samp_tick[c] && (bit_cnt_q[c] == div_m1);

        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                pre_cnt_q[c] <= 5'h00;
                ss_cnt_q[c]  <= 6'h00;
                bit_cnt_q[c] <= 6'h00;
            end else begin
                pre_cnt_q[c] <= pre_tick[c] ? 5'h00 : 5'(pre_cnt_q[c] + 5'h01);
                if (pre_tick[c]) begin
                    ss_cnt_q[c] <= (ss_cnt_q[c] >= ss_m1) ? 6'h00 : 6'(ss_cnt_q[c] + 6'h01);
                end
                if (samp_tick[c]) begin
                    bit_cnt_q[c] <= (bit_cnt_q[c] >= div_m1) ? 6'h00 : 6'(bit_cnt_q[c] + 6'h01);
                end
            end
        end

        asfb_buf2 #(.W(8)) u_buf (
            .clk_i       (clk_i),
            .reset_n_i   (reset_n_i),
            .in_valid_i  (wr_t[c]),
            .in_ready_o  (buf_rdy[c]),
            .in_data_i   (io_wdata_i),
            .out_valid_o (buf_vld[c]),
            .out_ready_i (take[c]),
            .out_data_o  (buf_dat[c])
        );

        wire asfb_pkg::asfb_fmt_s fmt = '{w8: mod_q[c][asfb_pkg::A_WIDTH],
                                          par_en: mod_q[c][asfb_pkg::A_PAR] & ~mp_q[c],
                                          stop2: mod_q[c][asfb_pkg::A_STOP],
                                          mp: mp_q[c], abts: abts_q[c], odd: odd_q[c]};
        assign frm[c]  = build_frame(fmt, buf_dat[c]);
        assign take[c] = (st_q[c] == asfb_pkg::TX_IDLE) && buf_vld[c];

        always_ff @(posedge clk_i) begin
            if (!reset_n_i) begin
                st_q[c]   <= asfb_pkg::TX_IDLE;
                sh_q[c]   <= '1;
                left_q[c] <= 4'h0;
                txd_q[c]  <= 1'b1;
                tx_buffer_empty_flag_q[c] <= 1'b0;
            end else begin
                tx_buffer_empty_flag_q[c] <= buf_rdy[c] && !cts_eff[c];
                unique case (st_q[c])
                    asfb_pkg::TX_IDLE: begin
                        if (take[c]) begin
                            sh_q[c]   <= frm[c].bits;
                            left_q[c] <= frm[c].len;
                            st_q[c]   <= asfb_pkg::TX_SHIFT;
                        end
                    end
                    asfb_pkg::TX_SHIFT: begin
                        if (bit_tick[c]) begin
                            txd_q[c]  <= sh_q[c][0];
                            sh_q[c]   <= {1'b1, sh_q[c][FW-1:1]};
                            left_q[c] <= 4'(left_q[c] - 4'h1);
                            if (left_q[c] == 4'h1) begin
                                st_q[c] <= asfb_pkg::TX_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Read path; the CTS bit follows the pin, never a reset value
    wire       sel = io_addr_i[0];
    wire [7:0] rd_a = {3'h0, ckdis_q[sel], 1'b0, mod_q[sel]};
    wire [7:0] rd_b = {abts_q[sel], mp_q[sel], cts_s_q[sel], odd_q[sel], dr_q[sel], ss_q[sel]};
    wire [7:0] rd_s = {6'h00, tx_buffer_empty_flag_q[sel], (st_q[sel] == asfb_pkg::TX_SHIFT)};
    wire       hit_a = (io_addr_i[7:1] == asfb_pkg::ADDR_CTRL_A0[7:1]);
    wire       hit_b = (io_addr_i[7:1] == asfb_pkg::ADDR_CTRL_B0[7:1]);
    wire       hit_s = (io_addr_i[7:1] == asfb_pkg::ADDR_STAT0[7:1]);
    wire [7:0] rd_mux = hit_a ? rd_a : hit_b ? rd_b : hit_s ? rd_s : asfb_pkg::RD_ZERO;

    logic [7:0] rdata_q;
    logic       ck0_dma_q, ck1_dma_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q   <= asfb_pkg::RD_ZERO;
            ck0_dma_q <= 1'b0;
            ck1_dma_q <= 1'b0;
        end else begin
            if (io_rd_i) begin
                rdata_q <= rd_mux;
            end
            ck0_dma_q <= dma0_io_mode_i;
            ck1_dma_q <= ckdis_q[1];
        end
    end

    assign io_rdata_o             = rdata_q;
    assign txd_o                  = txd_q;
    assign tx_buffer_empty_flag_o = tx_buffer_empty_flag_q;
    assign ck0_is_dma_o           = ck0_dma_q;
    assign ck1_is_dma_o           = ck1_dma_q;

    // Sample ticks seen since channel 0's last bit tick; a control B write may
    // move the divider in mid-bit, so that one bit is left unchecked
    logic [6:0] samp_seen_q;
    logic       div_moved_q;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || bit_tick[0]) begin
            samp_seen_q <= 7'h00;
            div_moved_q <= 1'b0;
        end else begin
            samp_seen_q <= 7'(samp_seen_q + {6'h00, samp_tick[0]});
            div_moved_q <= div_moved_q || wr_b[0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_tx_buffer_empty_flag_cts_inhibit: assert property (cts_s_q[0] |=> !tx_buffer_empty_flag_q[0])
        else $error("TX_BUFFER_EMPTY_FLAG set while CTS high");
    a_ch1_cts_select: assert property (cts_s_q[1] && ch1_cts_pin_select_i |=> !tx_buffer_empty_flag_q[1])
        else $error("Channel 1 TX_BUFFER_EMPTY_FLAG set while selected CTS high");
    a_cts_read_live: assert property (io_rd_i && io_addr_i == asfb_pkg::ADDR_CTRL_B0
                                      |=> io_rdata_o[asfb_pkg::B_CTSPS] == $past(cts_s_q[0]))
        else $error("CTS read bit does not follow pin");
    a_reset_ctrl_b: assert property (disable iff (1'b0) !reset_n_i |=>
                                     ss_q[0] == asfb_pkg::SS_RESET && !ps_q[0] && !dr_q[0] && !odd_q[0])
        else $error("Control B reset values wrong");
    a_prescale_ten: assert property (pre_tick[0] && !ps_q[0] ##1 (!pre_tick[0] && !ps_q[0])[*8]
                                     |=> !pre_tick[0] ##1 (pre_tick[0] || ps_q[0]))
        else $error("Prescale by 10 period wrong");
    a_bit_period_16: assert property (samp_tick[0] && bit_cnt_q[0] == 6'h00 && !dr_q[0] && ss_q[0] == 3'h0 && !ps_q[0]
                                      ##1 (!dr_q[0] && ss_q[0] == 3'h0 && !ps_q[0])[*8]
                                      |-> !bit_tick[0])
        else $error("Bit tick before sixteen samples");
    a_bit_period_div: assert property (bit_tick[0] && !div_moved_q |->
                                       samp_seen_q == (dr_q[0] ? 7'(asfb_pkg::DIV_HI_M1)
                                                               : 7'(asfb_pkg::DIV_LO_M1)))
        else $error("Bit tick after wrong number of samples");
    a_ext_clock_src: assert property (ss_q[0] == asfb_pkg::SS_EXT |-> samp_tick[0] == ck_rise[0])
        else $error("External source not used for code 7");
    a_mp_frame_len: assert property (take[0] && mp_q[0] |-> frm[0].len ==
                                     4'(4'h3 + {3'h0, mod_q[0][asfb_pkg::A_WIDTH]} + 4'h7
                                        + {3'h0, mod_q[0][asfb_pkg::A_STOP]}))
        else $error("Multiprocessor frame length wrong");
    a_mp_wake_bit: assert property (take[0] && mp_q[0] |=>
                                    sh_q[0][mod_q[0][asfb_pkg::A_WIDTH] ? 9 : 8] == $past(abts_q[0]))
        else $error("Address-wake bit does not match control bit");
    a_parity_sense: assert property (take[0] && !mp_q[0] && mod_q[0][asfb_pkg::A_PAR] && mod_q[0][asfb_pkg::A_WIDTH]
                                     |=> ^sh_q[0][9:1] == $past(odd_q[0]))
        else $error("Parity sense wrong");
    a_no_parity_len: assert property (take[0] && !mp_q[0] && !mod_q[0][asfb_pkg::A_PAR] |->
                                      frm[0].len == 4'(4'h9 + {3'h0, mod_q[0][asfb_pkg::A_WIDTH]}
                                                       + {3'h0, mod_q[0][asfb_pkg::A_STOP]}))
        else $error("Parity present without enable");
    a_dma_pin0: assert property (dma0_io_mode_i |=> ck0_is_dma_o)
        else $error("Pin 0 not reclaimed for DMA");

    c_mp_frame:  cover property (take[0] && mp_q[0]);
    c_par_frame: cover property (take[1] && mod_q[1][asfb_pkg::A_PAR] && odd_q[1]);
    c_ext_tick:  cover property (ss_q[0] == asfb_pkg::SS_EXT && bit_tick[0]);
    c_buf_full:  cover property (wr_t[0] && !buf_rdy[0]);
endmodule
`default_nettype wire

// ---- asfb_pkg.sv ----
// Package for the two-channel async serial format and bit-rate block.
// Assumes an 8-bit I/O port on the CPU side and a single 25 MHz system clock.
package asfb_pkg;

    // I/O addresses
    localparam logic [7:0] ADDR_CTRL_A0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL_A1 = 8'h01;
    localparam logic [7:0] ADDR_CTRL_B0 = 8'h02;
    localparam logic [7:0] ADDR_CTRL_B1 = 8'h03;
    localparam logic [7:0] ADDR_STAT0   = 8'h04;
    localparam logic [7:0] ADDR_STAT1   = 8'h05;
    localparam logic [7:0] ADDR_TXD0    = 8'h06;
    localparam logic [7:0] ADDR_TXD1    = 8'h07;

    // Control register B fields
    localparam int B_ABTS  = 7;
    localparam int B_MP    = 6;
    localparam int B_CTSPS = 5;
    localparam int B_ODD   = 4;
    localparam int B_DR    = 3;
    localparam int B_SS_HI = 2;

    // Control register A fields
    localparam int A_CKDIS = 4;
    localparam int A_WIDTH = 2;
    localparam int A_PAR   = 1;
    localparam int A_STOP  = 0;

    // Status fields
    localparam int STAT_TX_BUFFER_EMPTY_FLAG = 1;
    localparam int STAT_BUSY = 0;

    // Reset values and encodings
    localparam logic [2:0] SS_RESET = 3'h7;
    localparam logic [2:0] SS_EXT   = 3'h7;
    localparam logic [2:0] MOD_RESET = 3'h0;

    // Bit-rate dividers, stored as terminal counts
    localparam logic [4:0] PRESCALE_LO_M1 = 5'h09;   // divide by 10
    localparam logic [4:0] PRESCALE_HI_M1 = 5'h1D;   // divide by 30
    localparam logic [5:0] DIV_LO_M1      = 6'h0F;   // divide by 16
    localparam logic [5:0] DIV_HI_M1      = 6'h3F;   // divide by 64

    localparam int         FRAME_W = 12;
    localparam logic [7:0] RD_ZERO = 8'h00;

    typedef struct packed {
        logic w8;
        logic par_en;
        logic stop2;
        logic mp;
        logic abts;
        logic odd;
    } asfb_fmt_s;

    typedef struct packed {
        logic [FRAME_W-1:0] bits;
        logic [3:0]         len;
    } asfb_frame_s;

    typedef enum logic {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } asfb_tx_state_e;

endpackage

// ---- asfb_buf2.sv ----
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides on the same clock; a stall on the drain side fills it.
`timescale 1ns/10ps
`default_nettype none
module asfb_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,      // System clock
    input  wire logic         reset_n_i,  // Synchronous reset, low active
    input  wire logic         in_valid_i, // Word offered
    output logic              in_ready_o, // Room for a word
    input  wire logic [W-1:0] in_data_i,  // Offered word
    output logic              out_valid_o,// Word available
    input  wire logic         out_ready_i,// Drain takes word
    output logic [W-1:0]      out_data_o  // Oldest word
);
    logic [W-1:0] mem_q [2];
    logic         wp_q;
    logic         rp_q;
    logic [1:0]   cnt_q;
    wire          push = in_valid_i && (cnt_q != 2'h2);
    wire          pop  = out_ready_i && (cnt_q != 2'h0);

    assign in_ready_o  = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o  = mem_q[rp_q];

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            wp_q  <= wp_q ^ push;
            rp_q  <= rp_q ^ pop;
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// ---- asfb_rx_model.sv ----
// Behavioural serial receiver on one transmit line of the unit.
// Assumes the first data bit is 1, so the start bit's length gives the bit period.
`timescale 1ns/10ps
`default_nettype none
module asfb_rx_model (
    input  wire logic        clk_i,    // System clock
    input  wire logic        line_i,   // Serial line under watch
    input  wire logic [3:0]  len_i,    // Bits per frame with start
    output var  logic [11:0] frame_o,  // Last frame, first bit in bit 0
    output var  logic [31:0] period_o, // Start bit length in cycles
    output var  logic [31:0] count_o   // Frames seen
);
    initial begin
        count_o = 32'h0;
        period_o = 32'h0;
        frame_o = 12'h000;
        forever begin
            @(negedge line_i);
            @(negedge clk_i);
            period_o = 32'h0;
            // Counted on the opposite edge so no race with the line's update
            while (line_i === 1'b0) begin
                @(negedge clk_i);
                period_o++;
            end
            frame_o = 12'h000;
            repeat (period_o / 2) @(negedge clk_i);
            for (int i = 1; i < len_i; i++) begin
                frame_o[i] = line_i;
                if (i < len_i - 1) repeat (period_o) @(negedge clk_i);
            end
            count_o++;
        end
    end
endmodule
`default_nettype wire

// ---- tb_asfb_top.sv ----
// Self-checking bench: register port tasks, frame and bit-rate checks.
// Assumes the receiver model and the unit's package are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_asfb_top;
    localparam int EXT_HALF = 4;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  io_addr_i = 8'h00;
    logic        io_wr_i = 1'b0;
    logic        io_rd_i = 1'b0;
    logic [7:0]  io_wdata_i = 8'h00;
    logic [7:0]  io_rdata_o;
    logic [1:0]  cts_pin_i = 2'h1;
    logic        ch1_sel = 1'b0;
    logic [1:0]  ext_clk_pin_i = 2'h0;
    logic        dma0_io_mode_i = 1'b0;
    logic [1:0]  txd_o;
    logic [1:0]  tx_buffer_empty_flag_o;
    logic        ck0_is_dma_o;
    logic        ck1_is_dma_o;
    logic        ch = 1'b0;
    logic [3:0]  rx_len = 4'hA;
    logic [11:0] rx_frame;
    logic [31:0] rx_per;
    logic [31:0] rx_cnt;
    logic [7:0]  rd_v;
    logic [15:0] e;
    logic [31:0] n;
    int          mismatches = 0;
    int          tests_run = 0;
    logic [0:6] cf_ch = 7'b0101000;
    logic [7:0] cf_a [7] = '{8'h04, 8'h03, 8'h06, 8'h05, 8'h02, 8'h04, 8'h00};
    logic [7:0] cf_b [7] = '{8'h00, 8'h10, 8'h20, 8'hC8, 8'h41, 8'h07, 8'h02};
    logic [7:0] cf_d [7] = '{8'hA5, 8'h35, 8'h97, 8'h3B, 8'h6F, 8'h55, 8'h01};
    always #20 clk_i = ~clk_i;
    // Runs free; only heard while the clock-source field selects the pin
    always #(EXT_HALF * 40) ext_clk_pin_i = ~ext_clk_pin_i;
    asfb_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
        .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .cts_pin_i(cts_pin_i),
        .ch1_cts_pin_select_i(ch1_sel), .ext_clk_pin_i(ext_clk_pin_i), .dma0_io_mode_i(dma0_io_mode_i),
        .txd_o(txd_o), .tx_buffer_empty_flag_o(tx_buffer_empty_flag_o), .ck0_is_dma_o(ck0_is_dma_o),
        .ck1_is_dma_o(ck1_is_dma_o));
    asfb_rx_model rx (.clk_i(clk_i), .line_i(txd_o[ch]), .len_i(rx_len), .frame_o(rx_frame),
        .period_o(rx_per), .count_o(rx_cnt));
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1'b1;
        @(negedge clk_i);
        io_wr_i = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        io_addr_i = a;
        io_rd_i = 1'b1;
        @(negedge clk_i);
        io_rd_i = 1'b0;
        @(negedge clk_i);
        rd_v = io_rdata_o;
        cmp8(rd_v & m, x);
    endtask
    task automatic wait_frames(input logic [31:0] cnt);
        int k;
        k = 0;
        while (rx_cnt < cnt && k < 40000) begin
            @(negedge clk_i);
            k++;
        end
        if (k >= 40000) cmp32(rx_cnt, cnt);
    endtask
    function automatic logic [15:0] exp_frame(input logic [2:0] m, input logic [7:0] b, input logic [7:0] d);
        logic [11:0] f;
        logic [3:0]  k;
        logic        p;
        f = 12'h000;
        k = 4'h1;
        p = b[4];
        for (int i = 0; i < (m[2] ? 8 : 7); i++) begin
            f[k] = d[i];
            p = p ^ d[i];
            k++;
        end
        if (b[6] || m[1]) begin
            f[k] = b[6] ? b[7] : p;
            k++;
        end
        f[k] = 1'b1;
        f[k + 4'h1] = m[0];
        return {k + 4'h1 + {3'h0, m[0]}, f};
    endfunction
    function automatic logic [31:0] exp_per(input logic [7:0] b);
        if (b[2:0] == 3'h7) return 32'(16 * (b[3] ? 4 : 1) * 2 * EXT_HALF);
        return 32'((10 * (b[5] ? 3 : 1) * 16 * (b[3] ? 4 : 1)) << b[2:0]);
    endfunction
    task automatic end_of_test;
        $display("tests run %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_i);
        reset_n_i = 1'b1;
        // Channel 0 clear-to-send was high all through reset
        chk_rd(asfb_pkg::ADDR_CTRL_B0, 8'h7F, 8'h27);
        chk_rd(asfb_pkg::ADDR_CTRL_B1, 8'h7F, 8'h07);
        cmp8({6'h0, tx_buffer_empty_flag_o}, 8'h02);
        chk_rd(asfb_pkg::ADDR_STAT0, 8'h02, 8'h00);
        cmp8({6'h0, ck1_is_dma_o, ck0_is_dma_o}, 8'h00);
        cts_pin_i = 2'h2;
        repeat (4) @(negedge clk_i);
        cmp8({6'h0, tx_buffer_empty_flag_o}, 8'h03);
        ch1_sel = 1'b1;
        repeat (4) @(negedge clk_i);
        cmp8({6'h0, tx_buffer_empty_flag_o}, 8'h01);
        chk_rd(asfb_pkg::ADDR_CTRL_B1, 8'h20, 8'h20);
        cts_pin_i = 2'h0;
        repeat (4) @(negedge clk_i);
        cmp8({6'h0, tx_buffer_empty_flag_o}, 8'h03);
        chk_rd(8'h20, 8'hFF, 8'h00);
        dma0_io_mode_i = 1'b1;
        repeat (2) @(negedge clk_i);
        cmp8({7'h0, ck0_is_dma_o}, 8'h01);
        dma0_io_mode_i = 1'b0;
        io_wr(asfb_pkg::ADDR_CTRL_A1, 8'h10);
        cmp8({6'h0, ck1_is_dma_o, ck0_is_dma_o}, 8'h02);
        $display("test registers done");
        for (int t = 0; t < 7; t++) begin
            ch = cf_ch[t];
            e = exp_frame(cf_a[t][2:0], cf_b[t], cf_d[t]);
            rx_len = e[15:12];
            io_wr(asfb_pkg::ADDR_CTRL_A0 + {7'h0, ch}, cf_a[t]);
            io_wr(asfb_pkg::ADDR_CTRL_B0 + {7'h0, ch}, cf_b[t]);
            n = rx_cnt + 32'h1;
            io_wr(asfb_pkg::ADDR_TXD0 + {7'h0, ch}, cf_d[t]);
            wait_frames(n);
            cmp32({20'h0, rx_frame}, {20'h0, e[11:0]});
            cmp32(rx_per, exp_per(cf_b[t]));
            $display("test frame %0d done", t);
        end
        ch = 1'b0;
        io_wr(asfb_pkg::ADDR_CTRL_A0, 8'h04);
        io_wr(asfb_pkg::ADDR_CTRL_B0, 8'h00);
        rx_len = 4'hA;
        n = rx_cnt + 32'h3;
        for (int j = 0; j < 4; j++) io_wr(asfb_pkg::ADDR_TXD0, 8'h81 + 8'(2 * j));
        cmp8({7'h0, tx_buffer_empty_flag_o[0]}, 8'h00);
        e = exp_frame(3'h4, 8'h00, 8'h85);
        wait_frames(n);
        cmp32({20'h0, rx_frame}, {20'h0, e[11:0]});
        repeat (2000) @(negedge clk_i);
        cmp32(rx_cnt, n);
        cmp8({7'h0, tx_buffer_empty_flag_o[0]}, 8'h01);
        $display("test buffer done");
        end_of_test();
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
